// File: swr_defines.svh
// Command codes, field positions and timing constants of the read engine
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH
`define SWR_CMD_READ_BYTE 8'h96
`define SWR_CMD_TRIPLET 8'h78
`define SWR_DIR_BIT 7
`define SWR_STATUS_RST 1'b0
`define SWR_MCLK_NS 40
`define SWR_LINK_NS 80
`define SWR_START_MAX_PS 262500
`define SWR_SLOT_NS 70000
`define SWR_LOW1_NS 6000
`define SWR_LOW0_NS 60000
`define SWR_MSR_NS 15000
`define SWR_SLOT_CYC (`SWR_SLOT_NS / `SWR_LINK_NS)
`define SWR_LOW1_CYC ((`SWR_LOW1_NS + `SWR_LINK_NS - 1) / `SWR_LINK_NS)
`define SWR_LOW0_CYC ((`SWR_LOW0_NS + `SWR_LINK_NS - 1) / `SWR_LINK_NS)
`define SWR_MSR_CYC (`SWR_MSR_NS / `SWR_LINK_NS)
`define SWR_START_MAX_CYC (`SWR_START_MAX_PS / (`SWR_MCLK_NS * 1000))
// Busy bound in mclk cycles: eight slots plus crossing slack
`define SWR_BUSY_MAX_CYC \
   ((8 * `SWR_SLOT_NS + 2000) / `SWR_MCLK_NS)
`endif

// File: swr_pkg.sv
// State types of the read and triplet engine
package swr_pkg;
   typedef enum logic [2:0]
   {
      SWR_M_IDLE = 3'h1,
      SWR_M_WDIR = 3'h2,
      SWR_M_NDIR = 3'h4
   } swr_mstate_t;
   typedef enum logic [1:0]
   {
      SWR_L_IDLE = 2'h1,
      SWR_L_SLOT = 2'h2
   } swr_lstate_t;
endpackage

// File: swr_read_triplet.sv
// Single-wire byte read and triplet engine with result FIFO
//
// Summary of operation
// - Code 96h runs eight reads, stores byte
// - Byte read slots are write-one slots
// - Busy on 96h: nack, no bus activity
// - Byte read starts within 262.5ns of ack
// - Byte read ends within eight slots plus margin
// - Busy held high eight slots, then cleared
// - Host takes each byte from the result FIFO with rdReady
// - No new command while bus is active
// - Code 78h: two reads then one write
// - Reads 0,0: write follows direction bit
// - Reads 0,1: write zero
// - Reads 1,0: write one
// - Reads 1,1: still finish with write one
// - Busy on 78h: nack code and direction
// - Direction is bit 7 of parameter byte
// - Triplet starts fast, ends after three slots
// - First bit at first sample, rest later
// - Received bits assembled least significant first
`timescale 1ns/1ps
`include "swr_defines.svh"

module swr_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstB,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign inReady = count_q != (AW+1)'(DEPTH);
   assign outValid = count_q != '0;
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstB)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
         end
         if (pop)
         begin
            rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module swr_read_triplet
#(
   parameter int FIFO_DEPTH = 16
)
(
   // Host clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Command byte from host framing
   input wire logic cmdValid,
   input wire logic [7:0] cmdCode,
   output logic cmdAck_q,
   output logic cmdNack_q,
   // Parameter byte from host framing
   input wire logic paramValid,
   input wire logic [7:0] paramByte,
   output logic paramAck_q,
   output logic paramNack_q,
   // Status
   output logic wireBusyFlag_q,
   output logic singleBitResult_q,
   output logic tripletSecondBit_q,
   output logic branchDir_q,
   // Read data
   output logic rdValid_q,
   output logic [7:0] rdData_q,
   input wire logic rdReady,
   // Link side
   input wire logic linkClk,
   input wire logic wireIn,
   output logic wireOut_q,
   output logic wireOe_q
);
   localparam int CW = 10;
   localparam logic [CW-1:0] SLOT_CYC = CW'(`SWR_SLOT_CYC);
   localparam logic [CW-1:0] LOW1_CYC = CW'(`SWR_LOW1_CYC);
   localparam logic [CW-1:0] LOW0_CYC = CW'(`SWR_LOW0_CYC);
   localparam logic [CW-1:0] MSR_CYC = CW'(`SWR_MSR_CYC);
   localparam int BUSY_MAX = `SWR_BUSY_MAX_CYC;

   swr_pkg::swr_mstate_t mSt_q;
   logic reqTgl_q;
   logic mTrip_q;
   logic mDir_q;
   logic doneS1_q, doneS2_q, doneSeen_q;
   logic sbrS1_q, sbrS2_q, sbrSeen_q;
   logic tsbS1_q, tsbS2_q, tsbSeen_q;
   logic [7:0] res_q;
   logic pushValid_q;
   logic fifoInReady, fifoOutValid, fifoOutReady;
   logic [7:0] fifoOutData;
   logic isRead, isTrip, doneEv;
   logic [15:0] busyCnt_q;

   // Link-domain state
   swr_pkg::swr_lstate_t lSt_q;
   logic lRstS1_q, lRst_q;
   logic reqS1_q, reqS2_q, reqSeen_q;
   logic wireS1_q, wireS2_q;
   logic [CW-1:0] lCnt_q;
   logic [2:0] lSlot_q;
   logic lTrip_q, lDir_q, lR0_q, lSbr_q, lTsb_q, lWr_q;
   logic [7:0] lShift_q;
   logic lDoneTgl_q, lSbrTgl_q, lTsbTgl_q;
   logic lVal, lSample, lEnd, lLast, lPick;

   assign isRead = cmdCode == `SWR_CMD_READ_BYTE;
   assign isTrip = cmdCode == `SWR_CMD_TRIPLET;
   assign doneEv = doneS2_q != doneSeen_q;

   // Command framing and acknowledge; a full result FIFO counts as busy for 96h,
   // and so does a byte still on its way in, or it would be dropped
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         mSt_q <= swr_pkg::SWR_M_IDLE;
         cmdAck_q <= 1'b0;
         cmdNack_q <= 1'b0;
         paramAck_q <= 1'b0;
         paramNack_q <= 1'b0;
         reqTgl_q <= 1'b0;
         mTrip_q <= 1'b0;
         mDir_q <= 1'b0;
         wireBusyFlag_q <= `SWR_STATUS_RST;
      end
      else
      begin
         cmdAck_q <= 1'b0;
         cmdNack_q <= 1'b0;
         paramAck_q <= 1'b0;
         paramNack_q <= 1'b0;
         if (doneEv)
         begin
            wireBusyFlag_q <= 1'b0;
         end
         case (mSt_q)
            swr_pkg::SWR_M_IDLE:
            begin
               if (cmdValid && isRead)
               begin
                  if (wireBusyFlag_q || !fifoInReady || pushValid_q)
                  begin
                     cmdNack_q <= 1'b1;
                  end
                  else
                  begin
                     cmdAck_q <= 1'b1;
                     mTrip_q <= 1'b0;
                     reqTgl_q <= !reqTgl_q;
                     wireBusyFlag_q <= 1'b1;
                  end
               end
               else if (cmdValid && isTrip)
               begin
                  if (wireBusyFlag_q)
                  begin
                     cmdNack_q <= 1'b1;
                     mSt_q <= swr_pkg::SWR_M_NDIR;
                  end
                  else
                  begin
                     cmdAck_q <= 1'b1;
                     mSt_q <= swr_pkg::SWR_M_WDIR;
                  end
               end
            end
            swr_pkg::SWR_M_WDIR:
            begin
               if (paramValid)
               begin
                  paramAck_q <= 1'b1;
                  mTrip_q <= 1'b1;
                  mDir_q <= paramByte[`SWR_DIR_BIT];
                  reqTgl_q <= !reqTgl_q;
                  wireBusyFlag_q <= 1'b1;
                  mSt_q <= swr_pkg::SWR_M_IDLE;
               end
            end
            swr_pkg::SWR_M_NDIR:
            begin
               if (paramValid)
               begin
                  paramNack_q <= 1'b1;
                  mSt_q <= swr_pkg::SWR_M_IDLE;
               end
            end
            default:
            begin
               mSt_q <= swr_pkg::SWR_M_IDLE;
            end
         endcase
      end
   end

   // Event toggles back from the link; link registers are stable by now
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         doneS1_q <= 1'b0;
         doneS2_q <= 1'b0;
         doneSeen_q <= 1'b0;
         sbrS1_q <= 1'b0;
         sbrS2_q <= 1'b0;
         sbrSeen_q <= 1'b0;
         tsbS1_q <= 1'b0;
         tsbS2_q <= 1'b0;
         tsbSeen_q <= 1'b0;
      end
      else
      begin
         doneS1_q <= lDoneTgl_q;
         doneS2_q <= doneS1_q;
         doneSeen_q <= doneS2_q;
         sbrS1_q <= lSbrTgl_q;
         sbrS2_q <= sbrS1_q;
         sbrSeen_q <= sbrS2_q;
         tsbS1_q <= lTsbTgl_q;
         tsbS2_q <= tsbS1_q;
         tsbSeen_q <= tsbS2_q;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         singleBitResult_q <= `SWR_STATUS_RST;
         tripletSecondBit_q <= `SWR_STATUS_RST;
         branchDir_q <= `SWR_STATUS_RST;
         res_q <= 8'h00;
         pushValid_q <= 1'b0;
      end
      else
      begin
         pushValid_q <= doneEv && !mTrip_q;
         if (doneEv)
         begin
            res_q <= lShift_q;
         end
         if (sbrS2_q != sbrSeen_q)
         begin
            singleBitResult_q <= lSbr_q;
         end
         if (tsbS2_q != tsbSeen_q)
         begin
            tripletSecondBit_q <= lTsb_q;
            branchDir_q <= lWr_q;
         end
      end
   end

   swr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) resultFifo
   (
      .clk(mclk),
      .rstB(rst_b),
      .inValid(pushValid_q),
      .inReady(fifoInReady),
      .inData(res_q),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // Output register loads from the FIFO whenever it is empty or the host takes its byte
   assign fifoOutReady = !rdValid_q || rdReady;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         rdValid_q <= 1'b0;
         rdData_q <= 8'h00;
      end
      else if (fifoOutReady)
      begin
         rdValid_q <= fifoOutValid;
         rdData_q <= fifoOutData;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b || !wireBusyFlag_q)
      begin
         busyCnt_q <= 16'h0000;
      end
      else
      begin
         busyCnt_q <= busyCnt_q + 16'h0001;
      end
   end

   // Link domain: reset, request and pin pass two flops first
   always_ff @(posedge linkClk)
   begin
      lRstS1_q <= !rst_b;
      lRst_q <= lRstS1_q;
      reqS1_q <= reqTgl_q;
      reqS2_q <= reqS1_q;
      wireS1_q <= wireIn;
      wireS2_q <= wireS1_q;
   end

   // Write choice after two triplet reads
   assign lPick = (lR0_q != lTsb_q) ? lR0_q : (lR0_q | lDir_q);
   assign lVal = (lTrip_q && lSlot_q == 3'h2) ? lWr_q : 1'b1;
   assign lSample = lSt_q == swr_pkg::SWR_L_SLOT && lCnt_q == MSR_CYC;
   assign lEnd = lCnt_q == SLOT_CYC - 1'b1;
   assign lLast = lSlot_q == (lTrip_q ? 3'h2 : 3'h7);

   always_ff @(posedge linkClk)
   begin
      if (lRst_q)
      begin
         lSt_q <= swr_pkg::SWR_L_IDLE;
         reqSeen_q <= 1'b0;
         lCnt_q <= '0;
         lSlot_q <= 3'h0;
         lTrip_q <= 1'b0;
         lDir_q <= 1'b0;
         lDoneTgl_q <= 1'b0;
         wireOe_q <= 1'b0;
         wireOut_q <= 1'b0;
      end
      else
      begin
         case (lSt_q)
            swr_pkg::SWR_L_IDLE:
            begin
               if (reqS2_q != reqSeen_q)
               begin
                  reqSeen_q <= reqS2_q;
                  lTrip_q <= mTrip_q;
                  lDir_q <= mDir_q;
                  lSlot_q <= 3'h0;
                  lCnt_q <= '0;
                  wireOe_q <= 1'b1;
                  lSt_q <= swr_pkg::SWR_L_SLOT;
               end
            end
            swr_pkg::SWR_L_SLOT:
            begin
               lCnt_q <= lCnt_q + 1'b1;
               if (lCnt_q == (lVal ? LOW1_CYC : LOW0_CYC) - 1'b1)
               begin
                  wireOe_q <= 1'b0;
               end
               if (lEnd)
               begin
                  lCnt_q <= '0;
                  if (lLast)
                  begin
                     lDoneTgl_q <= !lDoneTgl_q;
                     lSt_q <= swr_pkg::SWR_L_IDLE;
                  end
                  else
                  begin
                     lSlot_q <= lSlot_q + 3'h1;
                     wireOe_q <= 1'b1;
                  end
               end
            end
            default:
            begin
               lSt_q <= swr_pkg::SWR_L_IDLE;
            end
         endcase
      end
   end

   // Sample point: byte shift and triplet results
   always_ff @(posedge linkClk)
   begin
      if (lRst_q)
      begin
         lShift_q <= 8'h00;
         lR0_q <= 1'b0;
         lSbr_q <= 1'b0;
         lTsb_q <= 1'b0;
         lWr_q <= 1'b0;
         lSbrTgl_q <= 1'b0;
         lTsbTgl_q <= 1'b0;
      end
      else if (lSample)
      begin
         if (!lTrip_q)
         begin
            lShift_q <= {wireS2_q, lShift_q[7:1]};
         end
         else if (lSlot_q == 3'h0)
         begin
            lR0_q <= wireS2_q;
            lSbr_q <= wireS2_q;
            lSbrTgl_q <= !lSbrTgl_q;
         end
         else if (lSlot_q == 3'h1)
         begin
            lTsb_q <= wireS2_q;
            lWr_q <= (lR0_q != wireS2_q) ? lR0_q : (lR0_q | lDir_q);
            lTsbTgl_q <= !lTsbTgl_q;
         end
      end
   end

   a_read_accept: assert property (@(posedge mclk)
      disable iff (!rst_b)
      cmdValid && isRead && mSt_q == swr_pkg::SWR_M_IDLE && !wireBusyFlag_q
      && fifoInReady && !pushValid_q
      |=> cmdAck_q && wireBusyFlag_q && reqTgl_q != $past(reqTgl_q))
      else $error("byte read not started");
   a_busy_nack: assert property (@(posedge mclk)
      disable iff (!rst_b)
      cmdValid && (isRead || isTrip) && mSt_q == swr_pkg::SWR_M_IDLE
      && wireBusyFlag_q |=> cmdNack_q && !cmdAck_q && $stable(reqTgl_q))
      else $error("command taken while busy");
   a_dir_nack: assert property (@(posedge mclk)
      disable iff (!rst_b)
      mSt_q == swr_pkg::SWR_M_NDIR && paramValid
      |=> paramNack_q && !paramAck_q && $stable(reqTgl_q))
      else $error("direction byte taken after refused code");
   a_dir_take: assert property (@(posedge mclk)
      disable iff (!rst_b)
      mSt_q == swr_pkg::SWR_M_WDIR && paramValid
      |=> mTrip_q && mDir_q == $past(paramByte[7]))
      else $error("direction bit not taken from bit 7");
   a_busy_span: assert property (@(posedge mclk)
      disable iff (!rst_b)
      $rose(wireBusyFlag_q) |-> wireBusyFlag_q[*8])
      else $error("busy dropped early");
   a_busy_bound: assert property (@(posedge mclk)
      disable iff (!rst_b)
      int'(busyCnt_q) <= BUSY_MAX)
      else $error("busy held too long");
   // The link reset flops are unknown until the host reset has reached
   // them, so the host reset also holds these checks off
   a_read_ones: assert property (@(posedge linkClk)
      disable iff (lRst_q || !rst_b)
      lSt_q == swr_pkg::SWR_L_SLOT && !lTrip_q && lCnt_q >= LOW1_CYC
      |-> !wireOe_q)
      else $error("byte read slot not write-one");
   a_write_pick: assert property (
      @(posedge linkClk) disable iff (lRst_q || !rst_b)
      lSt_q == swr_pkg::SWR_L_SLOT && lTrip_q && lSlot_q == 3'h2
      && lCnt_q == LOW1_CYC |-> wireOe_q == !lPick)
      else $error("triplet write slot wrong");
   a_lsb_first: assert property (@(posedge linkClk)
      disable iff (lRst_q || !rst_b)
      lSample && !lTrip_q |=> lShift_q[7] == $past(wireS2_q))
      else $error("bit not shifted in at the top");
   a_slot_count: assert property (@(posedge linkClk)
      disable iff (lRst_q || !rst_b)
      $changed(lDoneTgl_q)
      |-> $past(lSlot_q) == ($past(lTrip_q) ? 3'h2 : 3'h7))
      else $error("wrong number of slots");
   a_sbr_first: assert property (@(posedge linkClk)
      disable iff (lRst_q || !rst_b)
      lSample && lTrip_q && lSlot_q == 3'h0
      |=> lSbr_q == $past(wireS2_q) && $changed(lSbrTgl_q))
      else $error("first triplet bit not posted");
endmodule

// File: swr_wire_slave.sv
// Behavioural slave on the single-wire line, answering read slots
`timescale 1ns/1ps

module swr_wire_slave
(
   // Line levels
   input wire logic masterLow,
   input wire logic line,
   // Slave pull-down
   output logic slvLow
);
   bit txBits[$];
   int lowNs[$];
   int holdNs = 30000;
   realtime fallT;
   bit inLow = 1'b0;

   initial slvLow = 1'b0;

   // A zero is answered by holding the line low past the sample point;
   // an empty queue answers one, as an absent slave would
   always @(posedge masterLow)
   begin
      fallT = $realtime;
      inLow = 1'b1;
      if (txBits.size() > 0)
      begin
         if (!txBits.pop_front())
         begin
            slvLow <= 1'b1;
            slvLow <= #(holdNs) 1'b0;
         end
      end
   end

   // Low time of the master's own pulse tells the slot kind; the step
   // from unknown to low at reset is no pulse and is not recorded
   always @(negedge masterLow)
   begin
      if (inLow)
      begin
         lowNs.push_back(int'($realtime - fallT));
      end
      inLow = 1'b0;
   end
endmodule

// File: tb_top.sv
// Self-checking bench for the byte read and triplet engine
`timescale 1ns/1ps
`include "swr_defines.svh"
`define CHK(got, exp, msg) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("MISMATCH %0t %s", $time, msg); \
      end \
   end

module tb_top;
   localparam int SLOTM = `SWR_SLOT_NS / `SWR_MCLK_NS;
   logic mclk = 1'b0;
   logic linkClk = 1'b0;
   logic rst_b = 1'b0;
   logic cmdValid = 1'b0;
   logic [7:0] cmdCode = 8'h00;
   logic paramValid = 1'b0;
   logic [7:0] paramByte = 8'h00;
   logic rdReady = 1'b0;
   logic cmdAck_q, cmdNack_q, paramAck_q, paramNack_q;
   logic wireBusyFlag_q, singleBitResult_q, tripletSecondBit_q, branchDir_q;
   logic rdValid_q;
   logic [7:0] rdData_q;
   logic wireOut_q, wireOe_q, slvLow, line;
   logic [31:0] lfsr = 32'h1a9c9cef;
   logic [7:0] rdq[$];
   logic [2:0] cases [5] = '{3'b000, 3'b001, 3'b011, 3'b100, 3'b110};
   logic prevR2 = 1'b0;
   int num_errors = 0;
   int comparisons = 0;
   time tStart;

   // Open drain line with pull-up
   assign line = ~(wireOe_q & ~wireOut_q) & ~slvLow;

   always #20 mclk = ~mclk;
   // Link clock offset so its edges never meet the host clock's
   initial
   begin
      #7.3;
      forever #40 linkClk = ~linkClk;
   end

   swr_read_triplet #(.FIFO_DEPTH(2)) dut
   (
      .mclk(mclk), .rst_b(rst_b),
      .cmdValid(cmdValid), .cmdCode(cmdCode),
      .cmdAck_q(cmdAck_q), .cmdNack_q(cmdNack_q),
      .paramValid(paramValid), .paramByte(paramByte),
      .paramAck_q(paramAck_q), .paramNack_q(paramNack_q),
      .wireBusyFlag_q(wireBusyFlag_q),
      .singleBitResult_q(singleBitResult_q),
      .tripletSecondBit_q(tripletSecondBit_q), .branchDir_q(branchDir_q),
      .rdValid_q(rdValid_q), .rdData_q(rdData_q), .rdReady(rdReady),
      .linkClk(linkClk), .wireIn(line),
      .wireOut_q(wireOut_q), .wireOe_q(wireOe_q)
   );

   swr_wire_slave slave
   (
      .masterLow(wireOe_q & ~wireOut_q), .line(line), .slvLow(slvLow)
   );

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One byte on the command or parameter port, answer seen a cycle later
   task automatic send(input bit prm, input logic [7:0] val,
      input logic ack, input logic nack);
      @(negedge mclk);
      if (prm)
      begin
         paramByte = val;
         paramValid = 1'b1;
      end
      else
      begin
         cmdCode = val;
         cmdValid = 1'b1;
      end
      @(negedge mclk);
      paramValid = 1'b0;
      cmdValid = 1'b0;
      `CHK(prm ? paramAck_q : cmdAck_q, ack, "ack pulse")
      `CHK(prm ? paramNack_q : cmdNack_q, nack, "nack pulse")
   endtask

   task automatic wait_oe;
      int k;
      k = 0;
      while (wireOe_q !== 1'b1 && k < 12)
      begin
         @(negedge mclk);
         k++;
      end
      `CHK(wireOe_q, 1'b1, "line activity start")
   endtask

   task automatic wait_idle(input int lo, input int hi);
      int k;
      int n;
      k = 0;
      while (wireBusyFlag_q === 1'b1 && k < 20000)
      begin
         @(negedge mclk);
         k++;
      end
      n = int'(($time - tStart) / `SWR_MCLK_NS);
      `CHK(n >= lo && n <= hi, 1'b1, "busy span")
   endtask

   task automatic do_read(input bit inject);
      logic [7:0] b;
      int i;
      lfsr = lfsr_next(lfsr);
      b = lfsr[7:0];
      for (i = 0; i < 8; i++)
         slave.txBits.push_back(b[i]);
      rdq.push_back(b);
      send(0, `SWR_CMD_READ_BYTE, 1'b1, 1'b0);
      tStart = $time;
      `CHK(wireBusyFlag_q, 1'b1, "busy set")
      wait_oe();
      if (inject)
      begin
         send(0, `SWR_CMD_READ_BYTE, 1'b0, 1'b1);
         send(0, `SWR_CMD_TRIPLET, 1'b0, 1'b1);
         send(1, 8'hff, 1'b0, 1'b1);
         send(0, 8'ha5, 1'b0, 1'b0);
      end
      wait_idle(8 * SLOTM, `SWR_BUSY_MAX_CYC);
      `CHK(slave.lowNs.size(), 8, "slot count")
      for (i = 0; i < 8; i++)
         `CHK(slave.lowNs[i] < `SWR_MSR_NS, 1'b1, "write-one slot")
      slave.lowNs.delete();
   endtask

   task automatic do_trip(input logic r1, input logic r2, input logic v);
      logic w;
      lfsr = lfsr_next(lfsr);
      w = (r1 != r2) ? r1 : (r1 | v);
      slave.txBits.push_back(r1);
      slave.txBits.push_back(r2);
      send(0, `SWR_CMD_TRIPLET, 1'b1, 1'b0);
      send(1, {v, lfsr[6:0]}, 1'b1, 1'b0);
      tStart = $time;
      `CHK(wireBusyFlag_q, 1'b1, "busy set")
      wait_oe();
      // Between the first and the second sample point
      repeat (1000) @(negedge mclk);
      `CHK(singleBitResult_q, r1, "first bit early")
      `CHK(tripletSecondBit_q, prevR2, "second bit held")
      wait_idle(3 * SLOTM, 3 * SLOTM + 50);
      `CHK(slave.lowNs.size(), 3, "three slots")
      `CHK(slave.lowNs[0] < `SWR_MSR_NS, 1'b1, "read slot")
      `CHK(slave.lowNs[1] < `SWR_MSR_NS, 1'b1, "read slot")
      `CHK(slave.lowNs[2] > `SWR_MSR_NS, !w, "write kind")
      `CHK(tripletSecondBit_q, r2, "second bit")
      `CHK(branchDir_q, w, "branch value")
      prevR2 = r2;
      slave.lowNs.delete();
   endtask

   initial
   begin
      #(90000 * `SWR_MCLK_NS);
      num_errors++;
      final_report();
   end

   initial
   begin
      int k;
      int c;
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      `CHK(wireBusyFlag_q, 1'b0, "reset busy")
      `CHK(rdValid_q, 1'b0, "reset valid")
      `CHK(wireOe_q, 1'b0, "reset line")
      `CHK(rdData_q, 8'h00, "reset data")
      // Host stalls the data side: one byte waits at the output and
      // two more fill the store
      do_read(1'b1);
      do_read(1'b0);
      do_read(1'b0);
      // Full result store refuses a read without touching the line
      send(0, `SWR_CMD_READ_BYTE, 1'b0, 1'b1);
      repeat (30) @(negedge mclk);
      `CHK(slave.lowNs.size(), 0, "no activity when full")
      while (rdq.size() > 0)
      begin
         k = 0;
         while (rdValid_q !== 1'b1 && k < 50)
         begin
            @(negedge mclk);
            k++;
         end
         `CHK(rdData_q, rdq.pop_front(), "read byte")
         rdReady = 1'b1;
         @(negedge mclk);
         rdReady = 1'b0;
      end
      repeat (3) @(negedge mclk);
      `CHK(rdValid_q, 1'b0, "drained")
      // Back to back as in a search; five of the eight read and direction cases are run
      for (c = 0; c < 5; c++)
         do_trip(cases[c][2], cases[c][1], cases[c][0]);
      final_report();
   end
endmodule
